// [core/ccpm_pkg.sv]
// Behaviour
// - Mode 0000 turns the unit off and clears the capture prescaler, compare pin and PWM duty; flags and captured value are kept.
// - Capture on falling, rising, every fourth or every sixteenth rising input edge.
// - Mode 0010 toggles the compare pin on each timer match.
// - Mode 1000 drives the compare pin high on match and sets match flag.
// - Mode 1001 drives the compare pin low on match and sets match flag.
// - Mode 1010 only sets the match flag; compare pin stays unchanged.
// - Mode 1011 sets match flag and resets the selected timer pair's timer.
// - Fifth unit only: special event trigger also pulses converter_on.
// - PWM duty is ten bits: duty_high_byte upper eight, duty_low_bits lower two.
// - Capture or compare modes use output A; outputs B, C, D become port pins.
// - Half-bridge PWM with output_config 0x modulates A only; B is port.
// - Half-bridge PWM with output_config 1x drives A and B complementary.
// - Full-bridge output_config 00 modulates A only; B, C, D are port pins.
// - Full-bridge 01 forward: D modulated, A active, B and C inactive.
// - Full-bridge 10 modulates A and B complementary; C, D port pins.
// - Full-bridge 11 reverse: B modulated, C active, A and D inactive.
// - timer_select picks timer pair 1/2, 3/4 or 5/6; value 11 is reserved.
// - PWM polarity: mode bit 1 for A and C, bit 0 for B and D, one active-low.
package ccpm_pkg;
   localparam logic [7:0] CCPM_ADDR_CTRL = 8'h00;
   localparam logic [7:0] CCPM_ADDR_DUTY = 8'h04;
   localparam logic [7:0] CCPM_ADDR_CMPV = 8'h08;
   localparam logic [7:0] CCPM_ADDR_CAPV = 8'h0c;
   localparam logic [7:0] CCPM_ADDR_STAT = 8'h10;
   localparam int CCPM_MODE_LSB = 0;
   localparam int CCPM_DCLO_LSB = 4;
   localparam int CCPM_OCFG_LSB = 6;
   localparam int CCPM_TSEL_LSB = 8;
   localparam int CCPM_STAT_MATCH = 0;
   localparam int CCPM_STAT_CAP = 1;
   localparam logic [3:0] CCPM_MODE_OFF = 4'h0;
   localparam logic [3:0] CCPM_MODE_RSV1 = 4'h1;
   localparam logic [3:0] CCPM_MODE_TOGGLE = 4'h2;
   localparam logic [3:0] CCPM_MODE_RSV3 = 4'h3;
   localparam logic [3:0] CCPM_MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] CCPM_MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] CCPM_MODE_CAP_4TH = 4'h6;
   localparam logic [3:0] CCPM_MODE_CAP_16TH = 4'h7;
   localparam logic [3:0] CCPM_MODE_SET = 4'h8;
   localparam logic [3:0] CCPM_MODE_CLR = 4'h9;
   localparam logic [3:0] CCPM_MODE_SOFT = 4'ha;
   localparam logic [3:0] CCPM_MODE_SPECIAL = 4'hb;
   localparam logic [1:0] CCPM_GRP_CAP = 2'h1;
   localparam logic [1:0] CCPM_GRP_PWM = 2'h3;
   localparam logic [1:0] CCPM_TSEL_RSV = 2'h3;
   localparam logic [3:0] CCPM_PRESC_4TH = 4'h3;
   localparam logic [3:0] CCPM_PRESC_16TH = 4'hf;
   localparam logic [31:0] CCPM_RESET_WORD = 32'h0000_0000;
   localparam int CCPM_BRIDGE_STD = 0;
   localparam int CCPM_BRIDGE_HALF = 1;
   localparam int CCPM_BRIDGE_FULL = 2;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ccpm_apb_req_type;

   typedef struct packed {
      logic [2:0][15:0] cc_count;
      logic [2:0][9:0] pwm_count;
   } ccpm_timers_type;

   typedef struct packed {
      logic [3:0] pin_out;
      logic [3:0] pin_oe;
   } ccpm_pins_type;
endpackage

// [core/ccpm_pin_sync.sv]
module ccpm_pin_sync
   import ccpm_pkg::*;
(
   input wire logic pclk, // System clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable.
   input wire logic pin_raw, // Asynchronous pin level.
   output logic rise, // One-cycle pulse on an accepted rising change.
   output logic fall // One-cycle pulse on an accepted falling change.
);
   logic [2:0] sync_r;
   logic level_r;
   logic rise_r;
   logic fall_r;

   // The level only moves once stages two and three agree, so a one-cycle glitch never counts.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_r <= 3'h0;
         level_r <= 1'b0;
         rise_r <= 1'b0;
         fall_r <= 1'b0;
      end else if (ce) begin
         sync_r <= {sync_r[1:0], pin_raw};
         rise_r <= 1'b0;
         fall_r <= 1'b0;
         if (sync_r[1] == sync_r[2] && sync_r[2] != level_r) begin
            level_r <= sync_r[2];
            rise_r <= sync_r[2];
            fall_r <= ~sync_r[2];
         end
      end
   end

   assign rise = rise_r;
   assign fall = fall_r;
endmodule

// [core/ccpm_unit.sv]
// The implementer's own choices: the APB register port and the register addresses.
module ccpm_unit
   import ccpm_pkg::*;
#(
   parameter int BRIDGE = CCPM_BRIDGE_FULL, // 0 standard, 1 half-bridge, 2 full-bridge.
   parameter bit FIFTH_UNIT = 1'b0 // Only the fifth unit owns the converter trigger.
)
(
   input wire logic pclk, // System clock, 100 MHz.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable; low freezes all state.
   input wire ccpm_apb_req_type apb_req, // APB request signals.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on an unmapped address.
   input wire ccpm_timers_type timers, // Timer counts of all three pairs.
   input wire logic capture_pin, // Capture signal on output A, asynchronous.
   output ccpm_pins_type bridge_pins, // Levels and enables of outputs A to D.
   output logic [2:0] timer_reset, // Pulse resetting the selected capture timer.
   output logic converter_on // Pulse setting the converter-on bit.
);
   typedef struct packed {
      logic [3:0] mode_select;
      logic [1:0] duty_low_bits;
      logic [1:0] output_config;
      logic [1:0] timer_select;
      logic [7:0] duty_high_byte;
      logic [15:0] cmp_val;
      logic [15:0] cap_val;
      logic match_flag;
      logic cap_flag;
      logic [3:0] presc;
      logic cmp_pin;
      logic eq_prev;
      logic [9:0] duty_act;
      ccpm_pins_type pins;
      logic [2:0] tmr_rst;
      logic conv_on;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ccpm_state_type;

   ccpm_state_type s_r;
   ccpm_state_type s_nxt;
   logic cap_rise;
   logic cap_fall;

   ccpm_pin_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .pin_raw(capture_pin),
      .rise(cap_rise),
      .fall(cap_fall)
   );

   always_comb begin
      logic access;
      logic is_off;
      logic is_cap;
      logic is_pwm;
      logic tsel_ok;
      logic eq;
      logic match;
      logic cap_evt;
      logic pwm_raw;
      logic pol_ac;
      logic pol_bd;
      logic lvl_ac;
      logic lvl_bd;
      logic [1:0] tsel;
      logic [15:0] cc_now;
      logic [9:0] pwm_now;
      logic [3:0] new_mode;
      access = 1'b0;
      is_off = 1'b0;
      is_cap = 1'b0;
      is_pwm = 1'b0;
      tsel_ok = 1'b0;
      eq = 1'b0;
      match = 1'b0;
      cap_evt = 1'b0;
      pwm_raw = 1'b0;
      pol_ac = 1'b0;
      pol_bd = 1'b0;
      lvl_ac = 1'b0;
      lvl_bd = 1'b0;
      tsel = s_r.timer_select;
      cc_now = 16'h0000;
      pwm_now = 10'h000;
      new_mode = s_r.mode_select;
      s_nxt = s_r;
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      s_nxt.tmr_rst = 3'h0;
      s_nxt.conv_on = 1'b0;

      // Bus: the answer comes one cycle into the access phase, from registers.
      access = apb_req.psel & apb_req.penable & ~s_r.pready;
      if (access) begin
         s_nxt.pready = 1'b1;
         // Every read starts from zero, so bits with no field behind them read as zero.
         s_nxt.prdata = CCPM_RESET_WORD;
         case (apb_req.paddr)
            CCPM_ADDR_CTRL: begin
               if (apb_req.pwrite) begin
                  new_mode = apb_req.pwdata[CCPM_MODE_LSB +: 4];
                  s_nxt.mode_select = new_mode;
                  s_nxt.duty_low_bits = apb_req.pwdata[CCPM_DCLO_LSB +: 2];
                  s_nxt.timer_select = apb_req.pwdata[CCPM_TSEL_LSB +: 2];
                  if (BRIDGE != CCPM_BRIDGE_STD) begin
                     s_nxt.output_config = apb_req.pwdata[CCPM_OCFG_LSB +: 2];
                  end
               end
               s_nxt.prdata[CCPM_MODE_LSB +: 4] = s_r.mode_select;
               s_nxt.prdata[CCPM_DCLO_LSB +: 2] = s_r.duty_low_bits;
               s_nxt.prdata[CCPM_OCFG_LSB +: 2] = s_r.output_config;
               s_nxt.prdata[CCPM_TSEL_LSB +: 2] = s_r.timer_select;
            end
            CCPM_ADDR_DUTY: begin
               if (apb_req.pwrite) begin
                  s_nxt.duty_high_byte = apb_req.pwdata[7:0];
               end
               s_nxt.prdata[7:0] = s_r.duty_high_byte;
            end
            CCPM_ADDR_CMPV: begin
               if (apb_req.pwrite) begin
                  s_nxt.cmp_val = apb_req.pwdata[15:0];
               end
               s_nxt.prdata[15:0] = s_r.cmp_val;
            end
            CCPM_ADDR_CAPV: begin
               s_nxt.prdata[15:0] = s_r.cap_val;
            end
            CCPM_ADDR_STAT: begin
               if (apb_req.pwrite) begin
                  if (apb_req.pwdata[CCPM_STAT_MATCH]) begin
                     s_nxt.match_flag = 1'b0;
                  end
                  if (apb_req.pwdata[CCPM_STAT_CAP]) begin
                     s_nxt.cap_flag = 1'b0;
                  end
               end
               s_nxt.prdata[CCPM_STAT_MATCH] = s_r.match_flag;
               s_nxt.prdata[CCPM_STAT_CAP] = s_r.cap_flag;
            end
            default: begin
               s_nxt.pslverr = 1'b1;
            end
         endcase
      end

      // Mode decode from the registered field, so a write acts from the next cycle.
      // Reserved codes count as off, so a stray write never leaves a half-decoded mode.
      case (s_r.mode_select)
         CCPM_MODE_OFF, CCPM_MODE_RSV1, CCPM_MODE_RSV3: is_off = 1'b1;
         default: is_off = 1'b0;
      endcase
      is_cap = (s_r.mode_select[3:2] == CCPM_GRP_CAP);
      is_pwm = (s_r.mode_select[3:2] == CCPM_GRP_PWM);
      // The reserved pair selects no timer: no match, no capture, and PWM stays idle.
      tsel_ok = (tsel != CCPM_TSEL_RSV);
      if (tsel_ok) begin
         cc_now = timers.cc_count[tsel];
         pwm_now = timers.pwm_count[tsel];
      end

      // Match is an event: only the first cycle of equality counts.
      eq = tsel_ok && !is_off && !is_cap && !is_pwm && (cc_now == s_r.cmp_val);
      match = eq & ~s_r.eq_prev;
      s_nxt.eq_prev = eq;

      // Toggle mode leaves the flag alone; only the set, clear, flag-only and special modes raise it.
      if (match) begin
         case (s_r.mode_select)
            CCPM_MODE_TOGGLE: s_nxt.cmp_pin = ~s_r.cmp_pin;
            CCPM_MODE_SET: begin
               s_nxt.cmp_pin = 1'b1;
               s_nxt.match_flag = 1'b1;
            end
            CCPM_MODE_CLR: begin
               s_nxt.cmp_pin = 1'b0;
               s_nxt.match_flag = 1'b1;
            end
            CCPM_MODE_SOFT: s_nxt.match_flag = 1'b1;
            CCPM_MODE_SPECIAL: begin
               s_nxt.match_flag = 1'b1;
               s_nxt.tmr_rst[tsel] = 1'b1;
               s_nxt.conv_on = FIFTH_UNIT;
            end
            default: s_nxt.cmp_pin = s_r.cmp_pin;
         endcase
      end

      // Capture with edge prescaling; the flag set is placed after the clear so it wins.
      if (is_cap && tsel_ok) begin
         case (s_r.mode_select)
            CCPM_MODE_CAP_FALL: cap_evt = cap_fall;
            CCPM_MODE_CAP_RISE: cap_evt = cap_rise;
            CCPM_MODE_CAP_4TH: begin
               if (cap_rise) begin
                  cap_evt = (s_r.presc == CCPM_PRESC_4TH);
                  s_nxt.presc = cap_evt ? 4'h0 : s_r.presc + 4'h1;
               end
            end
            CCPM_MODE_CAP_16TH: begin
               if (cap_rise) begin
                  cap_evt = (s_r.presc == CCPM_PRESC_16TH);
                  s_nxt.presc = s_r.presc + 4'h1;
               end
            end
            default: cap_evt = 1'b0;
         endcase
      end
      if (cap_evt) begin
         s_nxt.cap_val = cc_now;
         s_nxt.cap_flag = 1'b1;
      end
      // A fresh capture mode counts edges from zero, even if the old mode saw an edge now.
      if (new_mode != s_r.mode_select) begin
         s_nxt.presc = 4'h0;
      end

      // PWM: the duty value is taken at the start of each period to avoid runt pulses.
      if (is_pwm && tsel_ok) begin
         if (pwm_now == 10'h000) begin
            s_nxt.duty_act = {s_r.duty_high_byte, s_r.duty_low_bits};
         end
         pwm_raw = (pwm_now < s_r.duty_act);
      end
      pol_ac = s_r.mode_select[1];
      pol_bd = s_r.mode_select[0];
      lvl_ac = pwm_raw ^ pol_ac;
      lvl_bd = pwm_raw ^ pol_bd;

      // Pin mapping; a zero enable hands the pin back to the port.
      s_nxt.pins.pin_out = 4'h0;
      s_nxt.pins.pin_oe = 4'h0;
      if (is_off) begin
         s_nxt.presc = 4'h0;
         s_nxt.cmp_pin = 1'b0;
         s_nxt.eq_prev = 1'b0;
         s_nxt.duty_act = 10'h000;
      end else if (!is_pwm) begin
         // Capture leaves A as an input; compare drives it. B to D stay port pins.
         s_nxt.pins.pin_out[0] = s_r.cmp_pin;
         s_nxt.pins.pin_oe[0] = ~is_cap;
      end else if (BRIDGE != CCPM_BRIDGE_FULL) begin
         s_nxt.pins.pin_out[0] = lvl_ac;
         s_nxt.pins.pin_oe[0] = 1'b1;
         // No dead-band delay: both halves switch on one edge, so the driver must add the gap.
         if (BRIDGE == CCPM_BRIDGE_HALF && s_r.output_config[1]) begin
            s_nxt.pins.pin_out[1] = ~pwm_raw ^ pol_bd;
            s_nxt.pins.pin_oe[1] = 1'b1;
         end
      end else begin
         // Bits run A, B, C, D from bit zero upward.
         // A held pin sits at the inverse of its polarity bit when active, at the bit when not.
         case (s_r.output_config)
            2'h0: begin
               s_nxt.pins.pin_out[0] = lvl_ac;
               s_nxt.pins.pin_oe[0] = 1'b1;
            end
            2'h1: begin
               s_nxt.pins.pin_out[0] = ~pol_ac;
               s_nxt.pins.pin_out[1] = pol_bd;
               s_nxt.pins.pin_out[2] = pol_ac;
               s_nxt.pins.pin_out[3] = lvl_bd;
               s_nxt.pins.pin_oe = 4'hf;
            end
            2'h2: begin
               s_nxt.pins.pin_out[0] = lvl_ac;
               s_nxt.pins.pin_out[1] = ~pwm_raw ^ pol_bd;
               s_nxt.pins.pin_oe[1:0] = 2'h3;
            end
            default: begin
               s_nxt.pins.pin_out[0] = pol_ac;
               s_nxt.pins.pin_out[1] = lvl_bd;
               s_nxt.pins.pin_out[2] = ~pol_ac;
               s_nxt.pins.pin_out[3] = pol_bd;
               s_nxt.pins.pin_oe = 4'hf;
            end
         endcase
      end
   end

   // With ce low nothing advances, the bus included, so no transfer may start then.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign bridge_pins = s_r.pins;
   assign timer_reset = s_r.tmr_rst;
   assign converter_on = s_r.conv_on;
endmodule

// [verification/ccpm_unit_properties.sv]
module ccpm_unit_properties
   import ccpm_pkg::*;
#(
   parameter int BRIDGE = CCPM_BRIDGE_FULL, // Bridge kind.
   parameter bit FIFTH_UNIT = 1'b0 // Converter trigger present.
)
(
   input wire logic pclk, // Clock.
   input wire logic presetn, // Reset, active low.
   input wire logic ce, // Clock enable.
   input wire ccpm_apb_req_type apb_req, // Bus request.
   input wire logic [31:0] prdata, // Read data.
   input wire logic pready, // Ready.
   input wire logic pslverr, // Error.
   input wire ccpm_timers_type timers, // Timer counts.
   input wire logic capture_pin, // Capture input.
   input wire ccpm_pins_type bridge_pins, // Bridge pins.
   input wire logic [2:0] timer_reset, // Timer clear pulses.
   input wire logic converter_on // Converter trigger.
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] ctrl_r;
   logic [1:0] age_r;
   logic [3:0] md;
   logic [3:0] po;
   logic [3:0] oe;
   logic ok;
   logic pwm;
   assign md = ctrl_r[3:0];
   assign po = bridge_pins.pin_out;
   assign oe = bridge_pins.pin_oe;
   assign ok = age_r == 2'd3;
   assign pwm = ok && md[3:2] == 2'b11 && BRIDGE == CCPM_BRIDGE_FULL;
   // Pins trail a control write by up to two cycles, so checks wait for three.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= 10'h000;
         age_r <= 2'd3;
      end else if (pready && !pslverr && apb_req.pwrite && apb_req.paddr == CCPM_ADDR_CTRL) begin
         ctrl_r <= apb_req.pwdata[9:0];
         age_r <= 2'd0;
      end else if (!ok) begin
         age_r <= age_r + 2'd1;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_off_released:
      assert property (ok && (md == 4'h0 || md == 4'h1 || md == 4'h3) |-> oe == 4'h0
         && timer_reset == 3'h0 && !converter_on) else $error("off unit drives");
   a_cc_port_pins:
      assert property (ok && md[3:2] != 2'b11 && md != 4'h0 && md != 4'h1 && md != 4'h3
         |-> oe == {3'h0, md[3] || md == 4'h2}) else $error("wrong pins in capture or compare");
   a_set_no_fall:
      assert property (ok && md == 4'h8 |-> !$fell(po[0])) else $error("set mode pin fell");
   a_clr_no_rise:
      assert property (ok && md == 4'h9 |-> !$rose(po[0])) else $error("clear mode pin rose");
   a_pin_kept:
      assert property (ok && (md == 4'ha || md == 4'hb) |-> $stable(po[0]))
         else $error("pin moved in flag-only mode");
   a_trigger_target:
      assert property (ok && timer_reset != 3'h0 |-> md == 4'hb && timer_reset == 3'h1 << ctrl_r[9:8])
         else $error("wrong timer cleared");
   a_converter_pair:
      assert property (timer_reset != 3'h0 || converter_on |->
         converter_on == (FIFTH_UNIT && timer_reset != 3'h0)) else $error("converter pulse wrong");
   a_single_out:
      assert property (pwm && ctrl_r[7:6] == 2'd0 |-> oe == 4'h1) else $error("single output pins");
   a_forward_drive:
      assert property (pwm && ctrl_r[7:6] == 2'd1 |-> oe == 4'hf && po[2:0] == {md[1], md[0], !md[1]})
         else $error("forward held pins wrong");
   a_pair_complement:
      assert property (pwm && ctrl_r[7:6] == 2'd2 |-> oe == 4'h3 && (po[0] ^ po[1]) == !(md[1] ^ md[0]))
         else $error("pair not complementary");
   a_reverse_drive:
      assert property (pwm && ctrl_r[7:6] == 2'd3 |-> oe == 4'hf && {po[3:2], po[0]} == {md[0], !md[1], md[1]})
         else $error("reverse held pins wrong");
endmodule

// [verification/ccpm_far_side.sv]
module ccpm_far_side
   import ccpm_pkg::*;
(
   input wire logic pclk, // System clock.
   input wire logic presetn, // Reset, active low.
   input wire logic [2:0] timer_reset, // Pulse clearing a capture timer.
   output ccpm_timers_type timers // Counts of the three timer pairs.
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pairs start 4096 apart so a compare on the wrong pair cannot match by chance.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 3; i++) begin
            timers.cc_count[i] <= 16'(i) << 12;
            timers.pwm_count[i] <= 10'h000;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (timer_reset[i]) begin
               timers.cc_count[i] <= 16'h0000;
            end else begin
               timers.cc_count[i] <= timers.cc_count[i] + 16'h0001;
            end
            timers.pwm_count[i] <= timers.pwm_count[i] + 10'h001;
         end
      end
   end
endmodule

// [verification/testbench.sv]
module testbench
   import ccpm_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ADDRS [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
   localparam logic [31:0] MASKS [3] = '{32'h0000_03ff, 32'h0000_00ff, 32'h0000_ffff};
   localparam logic [3:0] CMP_MODES [5] = '{4'h2, 4'h8, 4'h9, 4'ha, 4'hb};
   localparam int PWM_PIN [4] = '{0, 3, 0, 1};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic capture_pin = 1'b0;
   ccpm_apb_req_type req = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   ccpm_timers_type timers;
   ccpm_pins_type bridge_pins;
   logic [2:0] timer_reset;
   logic converter_on;
   logic [31:0] seed = 32'h438ba365;
   logic [31:0] q;
   logic err;
   int bad_count = 0;
   int check_count = 0;
   always #5 pclk = ~pclk;
   ccpm_unit #(.BRIDGE(CCPM_BRIDGE_FULL), .FIFTH_UNIT(1'b1)) ccpm_unit_i (.pclk(pclk),
      .presetn(presetn), .ce(ce), .apb_req(req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timers(timers), .capture_pin(capture_pin),
      .bridge_pins(bridge_pins), .timer_reset(timer_reset), .converter_on(converter_on));
   ccpm_far_side ccpm_far_side_i (.pclk(pclk), .presetn(presetn), .timer_reset(timer_reset),
      .timers(timers));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic int pwm_high(logic [3:0] m, int oc, int d);
      logic pol;
      pol = (oc == 1 || oc == 3) ? m[0] : m[1];
      return pol ? 1024 - d : d;
   endfunction
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic hang(input logic done);
      if (!done) begin
         bad_count++;
         $display("unexpected wait expected done seen timeout");
         end_of_test();
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      hang(pready === 1'b1);
      q = prdata;
      err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, q);
   endtask
   initial begin
      logic [31:0] c0;
      logic [3:0] m;
      logic [2:0] tr;
      logic [1:0] t;
      int n;
      int hi;
      int d;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 5; i++) begin
         rd(ADDRS[i], CCPM_RESET_WORD, "reset value");
      end
      apb(1'b0, 8'h14, 32'h0000_0000);
      chk("unmapped error", 32'h0000_0001, {31'h0, err});
      apb(1'b1, CCPM_ADDR_CAPV, rnd());
      rd(CCPM_ADDR_CAPV, 32'h0000_0000, "read-only capture");
      for (int i = 0; i < 3; i++) begin
         c0 = rnd();
         apb(1'b1, ADDRS[i], c0);
         rd(ADDRS[i], c0 & MASKS[i], "register readback");
      end
      apb(1'b1, CCPM_ADDR_CTRL, 32'h0000_0003);
      repeat (4) @(posedge pclk);
      chk("off enables", 32'h0, {28'h0, bridge_pins.pin_oe});
      $display("registers test done");
      foreach (CMP_MODES[i]) begin
         m = CMP_MODES[i];
         t = 2'(rnd() % 3);
         c0 = 32'(timers.cc_count[t]) + 32'd40;
         apb(1'b1, CCPM_ADDR_STAT, 32'h0000_0003);
         apb(1'b1, CCPM_ADDR_CMPV, c0);
         apb(1'b1, CCPM_ADDR_CTRL, {22'h0, t, 4'h0, m});
         n = 0;
         while (timers.cc_count[t] !== c0[15:0] && n < 200) begin
            @(posedge pclk);
            n++;
         end
         hang(n < 200);
         tr = 3'h0;
         repeat (4) begin
            @(posedge pclk);
            if (converter_on === 1'b1) tr = timer_reset;
         end
         chk("special pulse", (m == 4'hb) ? 32'(3'h1 << t) : 32'h0, 32'(tr));
         chk("compare pin", 32'(m == 4'h2 || m == 4'h8), 32'(bridge_pins.pin_out[0]));
         if (m[3]) rd(CCPM_ADDR_STAT, 32'h0000_0001, "match flag");
      end
      $display("compare test done");
      for (int k = 4; k < 8; k++) begin
         m = 4'(k);
         n = (m == 4'h6) ? 4 : (m == 4'h7) ? 16 : 1;
         apb(1'b1, CCPM_ADDR_CTRL, {28'h0, m});
         apb(1'b1, CCPM_ADDR_STAT, 32'h0000_0003);
         for (int j = 1; j <= n; j++) begin
            capture_pin <= 1'b1;
            c0 = 32'(timers.cc_count[0]);
            repeat (8) @(posedge pclk);
            rd(CCPM_ADDR_STAT, {30'h0, m != 4'h4 && j == n, 1'b0}, "capture flag");
            capture_pin <= 1'b0;
            // Falling-edge capture measures its lag from the fall, not from the rise.
            if (m == 4'h4) c0 = 32'(timers.cc_count[0]);
            repeat (8) @(posedge pclk);
         end
         rd(CCPM_ADDR_STAT, 32'h0000_0002, "capture flag");
         apb(1'b0, CCPM_ADDR_CAPV, 32'h0000_0000);
         chk("capture lag", 32'h1, 32'(q - c0 >= 32'd2 && q - c0 <= 32'd8));
      end
      $display("capture test done");
      for (int oc = 0; oc < 4; oc++) begin
         m = 4'hc | 4'(rnd());
         d = (oc == 0) ? 1023 : int'(rnd() & 32'h3ff);
         apb(1'b1, CCPM_ADDR_DUTY, 32'(d >> 2));
         apb(1'b1, CCPM_ADDR_CTRL, {24'h0, 2'(oc), 2'(d), m});
         repeat (2100) @(posedge pclk);
         hi = 0;
         repeat (1024) begin
            @(posedge pclk);
            if (bridge_pins.pin_out[PWM_PIN[oc]] === 1'b1) hi++;
         end
         chk("pwm high cycles", 32'(pwm_high(m, oc, d)), 32'(hi));
      end
      $display("pwm test done");
      ce <= 1'b0;
      @(posedge pclk);
      c0 = 32'(bridge_pins);
      repeat (40) @(posedge pclk);
      chk("frozen pins", c0, 32'(bridge_pins));
      ce <= 1'b1;
      $display("clock enable test done");
      end_of_test();
   end
endmodule
bind ccpm_unit ccpm_unit_properties #(.BRIDGE(BRIDGE), .FIFTH_UNIT(FIFTH_UNIT)) props_i (
   .pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .timers(timers), .capture_pin(capture_pin),
   .bridge_pins(bridge_pins), .timer_reset(timer_reset), .converter_on(converter_on));
